// >>> serial_channel_map.vh
// Register map, field positions, reset values and timing counts of serial channel zero
`ifndef SERIAL_CHANNEL_MAP_VH
`define SERIAL_CHANNEL_MAP_VH

// Register addresses
`define ADDR_POWER_CONTROL    8'h87
`define ADDR_SERIAL_CONTROL   8'h98
`define ADDR_SERIAL_BUFFER    8'h99
`define ADDR_BAUD_RELOAD_LOW  8'haa
`define ADDR_BAUD_RELOAD_HIGH 8'hba
`define ADDR_CONVERTER_CTRL0  8'hd8

// Field positions in serial_control
`define BIT_MODE_SELECT_HIGH  7
`define BIT_MODE_SELECT_LOW   6
`define BIT_MULTIPROC_ENABLE  5
`define BIT_RECEIVER_ENABLE   4
`define BIT_TX_NINTH_BIT      3
`define BIT_RX_NINTH_BIT      2
`define BIT_TX_DONE_FLAG      1
`define BIT_RX_DONE_FLAG      0

// Field positions in other registers
`define BIT_RATE_DOUBLE       7
`define BIT_GENERATOR_SELECT  7

// Reset values
`define RST_POWER_CONTROL     8'h00
`define RST_SERIAL_CONTROL    8'h00
`define RST_CONVERTER_CTRL0   8'h00
`define RST_BAUD_RELOAD_LOW   8'hd9
`define RST_BAUD_RELOAD_HIGH  2'h3

// Timing counts in oscillator cycles, oversampling ratio in ticks per bit
`define SHIFT_DIVIDE          12
`define LEGACY_DIVIDE         2496
`define OVERSAMPLE            16

`endif

// >>> serial_channel_zero_uart.v
// Serial channel zero: shift register mode and 8/9-bit asynchronous modes with baud generation
//
// Functional notes
// - 9-bit frame: start, 8 data, ninth, stop
// - Send tx ninth bit, store received ninth
// - Mode 3 equals mode 2 except rate
// - Buffer write starts a transmission
// - Mode 0 receive when flag clear, enabled
// - Async receive on start bit when enabled
// - Done flags set at stop bit start (tx) or centre (rx), at end in mode 0, pollable
// - Two mode bits select four modes
// - Buffer write transmits, read gives receive register
// - Multiproc: receive flag only if ninth one
// - Multiproc ignored mode 0, checks stop mode 1
// - Async logic runs at sixteen times baud
// - Mode 0 shifts at oscillator over twelve
// - Mode 2 rate oscillator over 64 or 32
// - Rate double bit doubles modes 1-3
// - Generator select picks dedicated or timer one
// - Timer one overflow over 32, doubled
// - New generator: 10-bit timer at half oscillator
// - Overflow reloads from both reload registers
// - Low reload write reloads timer immediately
// - New rate from reload value formula
// - Generator select also starts baud timer
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
`include "serial_channel_map.vh"

module serial_channel_zero_uart #(
  parameter LEGACY_GENERATOR = 0  // Nonzero selects the fixed 2496 prescaler
) (
  // Clock and reset
  input  wire       clk_sys,
  input  wire       rst,
  // Register port
  input  wire [7:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr,
  input  wire       rd,
  output reg  [7:0] rdata,
  // Timer one overflow pulse, same clock
  input  wire       timer_one_overflow,
  // Serial lines
  output reg        serial_out_line,
  input  wire       serial_in_line,
  output reg        serial_in_drive,
  output reg        serial_in_oe_n,
  // Channel request
  output reg        channel_request
);

  localparam [1:0] RX_IDLE = 2'b01;  // One-hot receiver states
  localparam [1:0] RX_RUN  = 2'b10;
  localparam integer LEGACY_FULL   = (`LEGACY_DIVIDE / 32) - 1;  // Base tick period minus one
  localparam [6:0]   LEGACY_CYCLES = LEGACY_FULL[6:0];           // Cut to the prescaler width
  localparam integer M0_HALF_FULL  = `SHIFT_DIVIDE / 2;          // Shift clock low phase length
  localparam [3:0]   M0_HALF       = M0_HALF_FULL[3:0];          // Cut to the bit counter width
  localparam integer M0_LAST_FULL  = `SHIFT_DIVIDE - 1;          // Last count of a shift bit
  localparam [3:0]   M0_LAST       = M0_LAST_FULL[3:0];          // Cut to the bit counter width

  // Software registers
  reg  [7:0] power_control;           // Rate double in bit 7
  reg  [7:0] converter_control_zero;  // Generator select in bit 7
  reg  [7:0] baud_reload_low;         // Low reload byte
  reg  [1:0] baud_reload_high;        // Upper two reload bits
  reg  [7:0] rx_buffer;               // Receive register
  reg        mode_select_high;
  reg        mode_select_low;
  reg        multiproc_enable;
  reg        receiver_enable;
  reg        tx_ninth_bit;
  reg        rx_ninth_bit;
  reg        tx_done_flag;
  reg        rx_done_flag;

  // Baud generation
  reg        osc_half;                // Toggles each cycle
  reg  [9:0] baud_timer;              // New 10-bit baud timer
  reg  [6:0] legacy_count;            // Legacy prescaler count
  reg        rate_half;               // Halves base tick when not doubled

  // Transmitter
  reg        tx_busy;
  reg [10:0] tx_shift;                // Current bit in bit 0
  reg  [3:0] tx_phase;
  reg  [3:0] tx_bit;
  reg  [3:0] tx_last;

  // Receiver
  reg        rx_sync1;                // Pin synchroniser first stage
  reg        rx_sync2;                // Pin synchroniser second stage
  reg        rx_prev;                 // Level seen at previous 16x tick
  reg  [1:0] rx_state;
  reg  [3:0] rx_phase;
  reg  [3:0] rx_bit;
  reg  [8:0] rx_shift;

  // Mode 0 shift engine
  reg        m0_active;
  reg        m0_rx;
  reg  [3:0] m0_count;
  reg  [2:0] m0_bits;
  reg  [7:0] m0_shift;

  // Decoded controls
  wire [1:0] mode        = {mode_select_high, mode_select_low};
  wire       mode0       = (mode == 2'b00);
  wire       nine        = mode_select_high;         // Modes 2 and 3
  wire       rate_double = power_control[`BIT_RATE_DOUBLE];
  wire       gen_select  = converter_control_zero[`BIT_GENERATOR_SELECT];
  wire       wr_ctrl     = wr && (addr == `ADDR_SERIAL_CONTROL);
  wire       wr_buf      = wr && (addr == `ADDR_SERIAL_BUFFER);
  wire       wr_rel_low  = wr && (addr == `ADDR_BAUD_RELOAD_LOW);

  // Compares a counter with its terminal value
  function at_end;
    input [3:0] value;
    input [3:0] limit;
    begin
      at_end = (value == limit);
    end
  endfunction

  // Baud sources
  wire       osc_div2    = osc_half;
  wire       new_ovf     = gen_select && osc_half && (baud_timer == 10'h3ff);
  wire       legacy_tick = gen_select && (legacy_count == LEGACY_CYCLES);
  wire       dedicated   = (LEGACY_GENERATOR != 0) ? legacy_tick : new_ovf;
  // Base tick is 32 times baud, or 16 times with rate double
  wire       base_tick   = (mode == 2'b10) ? osc_div2 :
                           (gen_select ? dedicated : timer_one_overflow);
  wire       tick16      = !mode0 && base_tick && (rate_double || rate_half);

  // Oscillator halving and rate halving stage
  always @(posedge clk_sys) begin
    if (rst) begin
      osc_half  <= 1'b0;
      rate_half <= 1'b0;
    end else begin
      osc_half <= ~osc_half;
      if (base_tick) begin
        rate_half <= ~rate_half;
      end
    end
  end

  // New baud timer: counts at half oscillator while selected, reloads on overflow or write
  always @(posedge clk_sys) begin
    if (rst) begin
      baud_timer <= {`RST_BAUD_RELOAD_HIGH, `RST_BAUD_RELOAD_LOW};
    end else if (wr_rel_low) begin
      baud_timer <= {baud_reload_high, wdata};
    end else if (new_ovf) begin
      baud_timer <= {baud_reload_high, baud_reload_low};
    end else if (gen_select && osc_half) begin
      baud_timer <= baud_timer + 10'h001;
    end
  end

  // Legacy fixed prescaler
  always @(posedge clk_sys) begin
    if (rst || !gen_select || legacy_tick) begin
      legacy_count <= 7'h00;
    end else begin
      legacy_count <= legacy_count + 7'h01;
    end
  end

  // Receive pin synchroniser
  always @(posedge clk_sys) begin
    if (rst) begin
      rx_sync1 <= 1'b1;
      rx_sync2 <= 1'b1;
    end else begin
      rx_sync1 <= serial_in_line;
      rx_sync2 <= rx_sync1;
    end
  end

  // Completion events of the engines
  wire tx_stop_start = tick16 && tx_busy && at_end(tx_phase, 4'hf) && at_end(tx_bit + 4'h1, tx_last);
  wire rx_sample     = tick16 && (rx_state == RX_RUN) && at_end(rx_phase, 4'h7);
  wire rx_stop_bit   = rx_sample && at_end(rx_bit, nine ? 4'ha : 4'h9);
  wire rx_ninth_val  = nine ? rx_shift[8] : rx_sync2;         // Stop bit in mode 1
  wire rx_accept     = rx_stop_bit && !rx_done_flag && (!multiproc_enable || rx_ninth_val);
  wire m0_bit_end    = m0_active && at_end(m0_count, M0_LAST);
  wire m0_done       = m0_bit_end && (m0_bits == 3'h7);
  wire m0_start_rx   = mode0 && receiver_enable && !rx_done_flag && !m0_active && !wr_buf;

  // Asynchronous transmitter
  always @(posedge clk_sys) begin
    if (rst) begin
      tx_busy  <= 1'b0;
      tx_shift <= 11'h7ff;
      tx_phase <= 4'h0;
      tx_bit   <= 4'h0;
      tx_last  <= 4'h9;
    end else if (wr_buf && !mode0) begin
      // Frame: stop, ninth or stop, data LSB first, start
      tx_busy  <= 1'b1;
      tx_shift <= nine ? {1'b1, tx_ninth_bit, wdata, 1'b0} : {2'b11, wdata, 1'b0};
      tx_phase <= 4'h0;
      tx_bit   <= 4'h0;
      tx_last  <= nine ? 4'ha : 4'h9;
    end else if (tick16 && tx_busy) begin
      tx_phase <= tx_phase + 4'h1;
      if (at_end(tx_phase, 4'hf)) begin
        tx_shift <= {1'b1, tx_shift[10:1]};
        tx_bit   <= tx_bit + 4'h1;
        if (at_end(tx_bit, tx_last)) begin
          tx_busy <= 1'b0;
        end
      end
    end
  end

  // Asynchronous receiver
  always @(posedge clk_sys) begin
    if (rst) begin
      rx_state <= RX_IDLE;
      rx_prev  <= 1'b1;
      rx_phase <= 4'h0;
      rx_bit   <= 4'h0;
      rx_shift <= 9'h000;
    end else if (tick16) begin
      rx_prev <= rx_sync2;
      case (rx_state)
        RX_IDLE: begin
          // Falling edge on the line starts a frame
          if (receiver_enable && rx_prev && !rx_sync2) begin
            rx_state <= RX_RUN;
            rx_phase <= 4'h0;
            rx_bit   <= 4'h0;
          end
        end
        RX_RUN: begin
          rx_phase <= rx_phase + 4'h1;
          if (at_end(rx_phase, 4'h7)) begin
            // Centre of bit
            if (at_end(rx_bit, 4'h0) && rx_sync2) begin
              rx_state <= RX_IDLE;                            // False start
            end else if (rx_stop_bit) begin
              rx_state <= RX_IDLE;
            end else if (!at_end(rx_bit, 4'h0)) begin
              rx_shift <= {rx_sync2, rx_shift[8:1]};
            end
            rx_bit <= rx_bit + 4'h1;
          end
        end
        default: begin
          rx_state <= RX_IDLE;
        end
      endcase
    end
  end

  // Mode 0 shift engine, twelve oscillator cycles per bit
  always @(posedge clk_sys) begin
    if (rst) begin
      m0_active <= 1'b0;
      m0_rx     <= 1'b0;
      m0_count  <= 4'h0;
      m0_bits   <= 3'h0;
      m0_shift  <= 8'h00;
    end else if (wr_buf && mode0) begin
      m0_active <= 1'b1;
      m0_rx     <= 1'b0;
      m0_count  <= 4'h0;
      m0_bits   <= 3'h0;
      m0_shift  <= wdata;
    end else if (m0_start_rx) begin
      m0_active <= 1'b1;
      m0_rx     <= 1'b1;
      m0_count  <= 4'h0;
      m0_bits   <= 3'h0;
    end else if (!mode0) begin
      m0_active <= 1'b0;
    end else if (m0_active) begin
      m0_count <= m0_bit_end ? 4'h0 : m0_count + 4'h1;
      // Receive samples at the rising shift clock
      if (m0_rx && at_end(m0_count, M0_HALF)) begin
        m0_shift <= {rx_sync2, m0_shift[7:1]};
      end
      if (m0_bit_end) begin
        m0_bits <= m0_bits + 3'h1;
        if (!m0_rx) begin
          m0_shift <= {1'b0, m0_shift[7:1]};
        end
        if (m0_done) begin
          m0_active <= 1'b0;
        end
      end
    end
  end

  // Serial control register, hardware set wins over software clear
  always @(posedge clk_sys) begin
    if (rst) begin
      {mode_select_high, mode_select_low, multiproc_enable, receiver_enable,
       tx_ninth_bit, rx_ninth_bit, tx_done_flag, rx_done_flag} <= `RST_SERIAL_CONTROL;
      rx_buffer <= 8'h00;
    end else begin
      if (wr_ctrl) begin
        mode_select_high <= wdata[`BIT_MODE_SELECT_HIGH];
        mode_select_low  <= wdata[`BIT_MODE_SELECT_LOW];
        multiproc_enable <= wdata[`BIT_MULTIPROC_ENABLE];
        receiver_enable  <= wdata[`BIT_RECEIVER_ENABLE];
        tx_ninth_bit     <= wdata[`BIT_TX_NINTH_BIT];
      end
      // Ninth bit: received bit, or stop bit in mode 1
      if (rx_accept) begin
        rx_ninth_bit <= rx_ninth_val;
        rx_buffer    <= nine ? rx_shift[7:0] : rx_shift[8:1];
      end else if (wr_ctrl) begin
        rx_ninth_bit <= wdata[`BIT_RX_NINTH_BIT];
      end
      if (m0_done && m0_rx) begin
        rx_buffer <= m0_shift;
      end
      // Done flags
      if (tx_stop_start || (m0_done && !m0_rx)) begin
        tx_done_flag <= 1'b1;
      end else if (wr_ctrl) begin
        tx_done_flag <= wdata[`BIT_TX_DONE_FLAG];
      end
      if (rx_accept || (m0_done && m0_rx)) begin
        rx_done_flag <= 1'b1;
      end else if (wr_ctrl) begin
        rx_done_flag <= wdata[`BIT_RX_DONE_FLAG];
      end
    end
  end

  // Other software registers
  always @(posedge clk_sys) begin
    if (rst) begin
      power_control          <= `RST_POWER_CONTROL;
      converter_control_zero <= `RST_CONVERTER_CTRL0;
      baud_reload_low        <= `RST_BAUD_RELOAD_LOW;
      baud_reload_high       <= `RST_BAUD_RELOAD_HIGH;
    end else if (wr) begin
      case (addr)
        `ADDR_POWER_CONTROL:    power_control          <= wdata;
        `ADDR_CONVERTER_CTRL0:  converter_control_zero <= wdata;
        `ADDR_BAUD_RELOAD_LOW:  baud_reload_low        <= wdata;
        `ADDR_BAUD_RELOAD_HIGH: baud_reload_high       <= wdata[1:0];
        default:                power_control          <= power_control;
      endcase
    end
  end

  // Read data, valid the cycle after the strobe
  always @(posedge clk_sys) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      case (addr)
        `ADDR_POWER_CONTROL:    rdata <= power_control;
        `ADDR_SERIAL_CONTROL:   rdata <= {mode_select_high, mode_select_low, multiproc_enable, receiver_enable,
                                          tx_ninth_bit, rx_ninth_bit, tx_done_flag, rx_done_flag};
        `ADDR_SERIAL_BUFFER:    rdata <= rx_buffer;
        `ADDR_BAUD_RELOAD_LOW:  rdata <= baud_reload_low;
        `ADDR_BAUD_RELOAD_HIGH: rdata <= {6'h00, baud_reload_high};
        `ADDR_CONVERTER_CTRL0:  rdata <= converter_control_zero;
        default:                rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // Pin drivers and request, all registered
  always @(posedge clk_sys) begin
    if (rst) begin
      serial_out_line <= 1'b1;
      serial_in_drive <= 1'b1;
      serial_in_oe_n  <= 1'b1;
      channel_request <= 1'b0;
    end else begin
      channel_request <= tx_done_flag || rx_done_flag;
      if (mode0) begin
        // Shift clock low for first half of each bit
        serial_out_line <= !(m0_active && (m0_count < M0_HALF));
        serial_in_drive <= m0_active ? m0_shift[0] : 1'b1;
        serial_in_oe_n  <= !(m0_active && !m0_rx);
      end else begin
        serial_out_line <= tx_busy ? tx_shift[0] : 1'b1;
        serial_in_drive <= 1'b1;
        serial_in_oe_n  <= 1'b1;
      end
    end
  end

endmodule // serial_channel_zero_uart

// >>> serial_channel_checker_sva.sv
// Port checker for serial channel zero
`timescale 1ns/1ps
`include "serial_channel_map.vh"
module serial_channel_checker #(
  parameter LEGACY_GENERATOR = 0  // Generator kind of the block
) (
  // Clock, reset and register port
  input wire       clk_sys,
  input wire       rst,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire       wr,
  input wire       rd,
  input wire [7:0] rdata,
  input wire       timer_one_overflow,
  // Serial pins and request
  input wire       serial_out_line,
  input wire       serial_in_line,
  input wire       serial_in_drive,
  input wire       serial_in_oe_n,
  input wire       channel_request
);
  reg  [1:0] mode;                                  // Mode bits mirrored from writes
  wire       mode_async = (mode != 2'b00);          // Any asynchronous mode
  wire       wr_buf = wr && addr == `ADDR_SERIAL_BUFFER;
  wire       mapped = addr == `ADDR_POWER_CONTROL || addr == `ADDR_SERIAL_CONTROL ||
                      addr == `ADDR_SERIAL_BUFFER || addr == `ADDR_BAUD_RELOAD_LOW ||
                      addr == `ADDR_BAUD_RELOAD_HIGH || addr == `ADDR_CONVERTER_CTRL0;
  // Mirror the mode selection
  always @(posedge clk_sys) begin
    if (rst) begin
      mode <= 2'b00;
    end else if (wr && addr == `ADDR_SERIAL_CONTROL) begin
      mode <= wdata[7:6];
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  AST_RESET_IDLE: assert property (disable iff (1'b0) rst |=> serial_out_line && serial_in_oe_n && !channel_request && rdata == 8'h00)
    else $error("outputs not idle after reset");
  AST_QUIET_READ: assert property (!(rd && mapped) |=> rdata == 8'h00)
    else $error("read data not zero");
  AST_CONTROL_READBACK: assert property (wr && addr == `ADDR_SERIAL_CONTROL ##2 rd && addr == `ADDR_SERIAL_CONTROL |=> rdata[7:3] == $past(wdata[7:3], 3))
    else $error("control bits not read back");
  AST_RELOAD_READBACK: assert property (wr && addr == `ADDR_BAUD_RELOAD_LOW ##2 rd && addr == `ADDR_BAUD_RELOAD_LOW |=> rdata == $past(wdata, 3))
    else $error("reload low not read back");
  AST_ASYNC_START: assert property (wr_buf && mode_async |-> ##2 !serial_out_line)
    else $error("no start bit after buffer write");
  AST_SHIFT_CLOCK: assert property (wr_buf && !mode_async |-> ##2 (!serial_out_line)[*6] ##1 serial_out_line[*6])
    else $error("shift clock shape wrong");
  AST_SHIFT_DATA: assert property (wr_buf && !mode_async |-> ##2 serial_in_drive == $past(wdata[0], 2) && !serial_in_oe_n)
    else $error("shift data not driven lsb first");
  AST_ASYNC_PIN_IDLE: assert property (mode_async [*3] |-> serial_in_oe_n)
    else $error("data pin driven in async mode");
  AST_REQUEST_FLAGS: assert property ($past(rd) && $past(addr) == `ADDR_SERIAL_CONTROL |-> channel_request == (rdata[1] | rdata[0]))
    else $error("request differs from flags");
  // Main scenarios
  COV_ASYNC_TX: cover property (wr_buf && mode_async);
  COV_SHIFT_TX: cover property (wr_buf && !mode_async);
  COV_REQUEST: cover property ($rose(channel_request));
endmodule // serial_channel_checker

bind serial_channel_zero_uart serial_channel_checker #(.LEGACY_GENERATOR(LEGACY_GENERATOR)) chk (
  .clk_sys(clk_sys), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .timer_one_overflow(timer_one_overflow), .serial_out_line(serial_out_line), .serial_in_line(serial_in_line),
  .serial_in_drive(serial_in_drive), .serial_in_oe_n(serial_in_oe_n), .channel_request(channel_request));

// >>> serial_node.sv
// Partner serial node on the far side of the link
`timescale 1ns/1ps
module serial_node (
  // Clock
  input  wire clk_sys,
  // Link lines
  input  wire line_in,
  input  wire data_pin,
  output reg  line_out
);
  initial line_out = 1'b1;  // Idle high like the pulled-up pin
  // Send start, data lsb first, stop
  task automatic send(input [8:0] v, input int nb, input int bc);
    int i;
    for (i = -1; i <= nb; i++) begin
      @(posedge clk_sys);
      line_out <= (i < 0) ? 1'b0 : (i == nb) ? 1'b1 : v[i];
      repeat (bc - 1) @(posedge clk_sys);
    end
    @(posedge clk_sys);
  endtask
  // Catch a frame at bit centres; unknown if none starts
  task automatic catch_frame(input int nb, input int bc, output [9:0] f);
    int i;
    f = 10'bx;
    for (i = 0; i < 5000 && line_in; i++) @(negedge clk_sys);
    if (!line_in) begin
      f = 10'h000;
      repeat (bc / 2) @(negedge clk_sys);
      for (i = 0; i <= nb; i++) begin
        repeat (bc) @(negedge clk_sys);
        f[i] = line_in;
      end
    end
    @(posedge clk_sys);
  endtask
  // Mode 0: new bit at falling shift clock, data pin read at rising
  task automatic shift_bits(input [7:0] v, output [7:0] seen);
    int i;
    for (i = 0; i < 8; i++) begin
      @(negedge line_in);
      line_out <= v[i];
      @(posedge line_in);
      seen[i] = data_pin;
    end
    line_out <= 1'b1;
  endtask
endmodule // serial_node

// >>> serial_channel_zero_uart_tb.sv
// Self-checking bench for serial channel zero
`timescale 1ns/1ps
`include "serial_channel_map.vh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; $display("[FAIL] %s expected %h got %h", nm, e, g); end end
module serial_channel_zero_uart_tb;
  reg        clk_sys = 1'b0;  // Oscillator clock
  reg        rst = 1'b1;      // Synchronous reset
  reg  [7:0] addr = 8'h00;    // Register address
  reg  [7:0] wdata = 8'h00;   // Write data
  reg        wr = 1'b0;       // Write strobe
  reg        rd = 1'b0;       // Read strobe
  reg        t1_ovf = 1'b0;   // Timer one overflow
  wire [7:0] rdata;           // Read data
  wire       tx_line;         // Device transmit line
  wire       node_line;       // Partner line toward device
  wire       drv;             // Device drive of data pin
  wire       oe_n;            // Device enable of data pin
  wire       req;             // Channel request
  wire       pin_in = oe_n ? node_line : drv;  // Resolved data pin
  int        num_errors = 0;
  int        n_checks = 0;
  reg  [9:0] got;             // Frame seen by partner
  reg  [8:0] d, e;            // Random payloads
  reg  [7:0] last;            // Last byte received
  reg  [7:0] ra [7] = '{8'h87, 8'h98, 8'h99, 8'haa, 8'hba, 8'hd8, 8'h10};
  reg  [7:0] rv [7] = '{8'h00, 8'h00, 8'h00, 8'hd9, 8'h03, 8'h00, 8'h00};
  serial_channel_zero_uart DUT (.clk_sys(clk_sys), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .timer_one_overflow(t1_ovf), .serial_out_line(tx_line), .serial_in_line(pin_in),
    .serial_in_drive(drv), .serial_in_oe_n(oe_n), .channel_request(req));
  serial_node node (.clk_sys(clk_sys), .line_in(tx_line), .data_pin(pin_in), .line_out(node_line));
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic wr_reg(input [7:0] a, input [7:0] v);
    addr <= a; wdata <= v; wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd_chk(input [7:0] a, input [7:0] x, input [7:0] m, input string nm);
    addr <= a; rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 `CHK(nm, x & m, rdata & m)
    @(posedge clk_sys);
  endtask
  // One transmit and one receive frame in an async mode
  task automatic async_case(input [1:0] m, input [7:0] pc, input [7:0] ad, input int bc, input string nm);
    int nb;
    nb = (m == 2'b01) ? 8 : 9;
    d = 9'($urandom);
    e = 9'($urandom);
    wr_reg(`ADDR_POWER_CONTROL, pc);
    wr_reg(`ADDR_CONVERTER_CTRL0, ad);
    wr_reg(`ADDR_SERIAL_CONTROL, {m, 2'b01, d[8], 3'b000});
    fork
      node.catch_frame(nb, bc, got);
      wr_reg(`ADDR_SERIAL_BUFFER, d[7:0]);
    join
    `CHK("tx data", d[7:0], got[7:0])
    `CHK("tx ninth", (nb == 9) ? d[8] : 1'b1, got[8])
    `CHK("tx stop", 1'b1, got[nb])
    rd_chk(`ADDR_SERIAL_CONTROL, 8'h02, 8'h03, "tx flag");
    `CHK("request", 1'b1, req)
    wr_reg(`ADDR_SERIAL_CONTROL, {m, 2'b01, d[8], 3'b000});
    node.send(e, nb, bc);
    rd_chk(`ADDR_SERIAL_BUFFER, e[7:0], 8'hff, "rx data");
    rd_chk(`ADDR_SERIAL_CONTROL, {m, 2'b01, d[8], (nb == 9) ? e[8] : 1'b1, 2'b01}, 8'hff, "rx flags");
    last = e[7:0];
    $display("test %s done", nm);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Watchdog against a hung run
  initial begin
    repeat (40000) @(posedge clk_sys);
    num_errors++;
    give_verdict();
  end
  // Main sequence
  initial begin
    void'($urandom(32'h1feffd48));
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    foreach (ra[i]) rd_chk(ra[i], rv[i], 8'hff, "reset value");
    `CHK("request idle", 1'b0, req)
    $display("test reset done");
    t1_ovf <= 1'b1;
    async_case(2'b01, 8'h80, 8'h00, 16, "mode1 timer");
    async_case(2'b10, 8'h00, 8'h00, 64, "mode2 slow");
    wr_reg(`ADDR_BAUD_RELOAD_HIGH, 8'h03);
    wr_reg(`ADDR_BAUD_RELOAD_LOW, 8'hff);
    rd_chk(`ADDR_BAUD_RELOAD_LOW, 8'hff, 8'hff, "reload low");
    async_case(2'b11, 8'h80, 8'h80, 32, "mode3 generator");
    async_case(2'b10, 8'h80, 8'h00, 32, "mode2 fast");
    wr_reg(`ADDR_SERIAL_CONTROL, 8'hb0);
    rd_chk(`ADDR_SERIAL_CONTROL, 8'hb0, 8'hff, "multiproc on");
    e = {1'b0, 8'($urandom)};
    node.send(e, 9, 32);
    rd_chk(`ADDR_SERIAL_CONTROL, 8'h00, 8'h01, "data frame dropped");
    rd_chk(`ADDR_SERIAL_BUFFER, last, 8'hff, "buffer kept");
    e = {1'b1, 8'($urandom)};
    node.send(e, 9, 32);
    rd_chk(`ADDR_SERIAL_CONTROL, 8'h05, 8'h05, "address frame");
    rd_chk(`ADDR_SERIAL_BUFFER, e[7:0], 8'hff, "address byte");
    $display("test multiproc done");
    wr_reg(`ADDR_SERIAL_CONTROL, 8'h00);
    d = {1'b0, 8'($urandom)};
    // Mode 0 transmit, partner reads the data pin
    fork
      node.shift_bits(8'hff, got[7:0]);
      wr_reg(`ADDR_SERIAL_BUFFER, d[7:0]);
    join
    repeat (8) @(posedge clk_sys);
    `CHK("shift tx data", d[7:0], got[7:0])
    rd_chk(`ADDR_SERIAL_CONTROL, 8'h02, 8'h03, "shift done");
    // Mode 0 receive starts once enabled with the flag clear
    e = {1'b0, 8'($urandom)};
    fork
      node.shift_bits(e[7:0], got[7:0]);
      wr_reg(`ADDR_SERIAL_CONTROL, 8'h10);
    join
    repeat (8) @(posedge clk_sys);
    rd_chk(`ADDR_SERIAL_BUFFER, e[7:0], 8'hff, "shift rx data");
    rd_chk(`ADDR_SERIAL_CONTROL, 8'h11, 8'hff, "shift rx flags");
    $display("test mode0 done");
    give_verdict();
  end
endmodule // serial_channel_zero_uart_tb
